// ### include/idec_map.vh
/*
  Constants for the instruction decoder: word layout, group codes, cycle
  timing and identification-storage addresses.
  Assumes plain Verilog-2005 inclusion by bare name.
*/
`ifndef IDEC_MAP_VH
`define IDEC_MAP_VH
`define IW_WIDTH      14
`define IW_GRP_HI     13
`define IW_GRP_LO     12
`define IW_DEST_BIT   7
`define IW_FILE_HI    6
`define IW_BIT_HI     9
`define IW_BIT_LO     7
`define IW_K8_HI      7
`define IW_K11_HI     10
`define IW_LIT11_BIT  11
`define GRP_BYTE      2'h0
`define GRP_BIT       2'h1
`define GRP_CTRL      2'h2
`define GRP_LIT       2'h3
`define OSC_PER_CYC   4
`define PHASE_LAST    2'h3
`define PHASE_FIRST   2'h0
`define ID_BASE       14'h2000
`define ID_LAST       14'h2003
`define PA_WIDTH      14
`define ID_WORDS      4
`endif

// ### verilog/id_store.v
/*
  Four-word identification store with registered read data.
  Assumes the caller only asserts write or read while access is permitted.
*/
module id_store (
  input  wire        clk,
  input  wire        resetn,
  input  wire        wrEn,
  input  wire [1:0]  addr,
  input  wire [13:0] wrData,
  output reg  [13:0] rdData_ff
);
  reg [13:0] mem [0:3];

  always @(posedge clk) begin
    if (wrEn) begin
      mem[addr] <= wrData;
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      rdData_ff <= 14'h0000;
    end else begin
      rdData_ff <= mem[addr];
    end
  end
endmodule // id_store

// ### verilog/mcu_instruction_decode_idloc.v
/*
  Instruction decoder with phase sequencer, program-verify readout gate and
  identification-storage words.
  Assumes the datapath presents a new instruction word and the branch/skip
  outcome at the last phase of each instruction cycle, and that program
  memory data arrive on progMemData in the same cycle as the address.
*/
// Operation
// - Program memory readout allowed only while protection stays unprogrammed.
// - Four identification words live at addresses 2000h to 2003h.
// - Identification words reachable only in program/verify mode, read and write.
// - Every instruction is one 14-bit word: opcode then operands.
// - Instructions fall into byte, bit and literal/control groups.
// - Destination zero writes accumulator, one writes the file register.
// - File operand selects register address 0x00 to 0x7F.
// - Bit-select field picks one of eight bits of the file register.
// - Literal operand is eight or eleven bits depending on instruction.
// - Don't-care bits never influence decoding.
// - One cycle per instruction; taken test or branch adds a no-op cycle.
// - An instruction cycle spans four oscillator periods.
`include "idec_map.vh"
module mcu_instruction_decode_idloc (
  input  wire        clk,
  input  wire        resetn,
  input  wire [13:0] instrWord,
  input  wire        pcChange,
  input  wire        progVerifyMode,
  input  wire        protectProgrammed,
  input  wire [13:0] pgmAddr,
  input  wire [13:0] pgmWrData,
  input  wire        pgmWrite,
  input  wire        pgmRead,
  input  wire [13:0] progMemData,
  output reg  [1:0]  phase_ff,
  output reg         cycleEnd_ff,
  output reg         isByteOp_ff,
  output reg         isBitOp_ff,
  output reg         isLitCtrl_ff,
  output reg         destFile_ff,
  output reg         destAcc_ff,
  output reg  [6:0]  fileAddr_ff,
  output reg  [2:0]  bitSel_ff,
  output reg  [10:0] literal_ff,
  output reg         literalWide_ff,
  output reg         writeEn_ff,
  output reg         statusEn_ff,
  output reg         flushing_ff,
  output reg  [13:0] verifyData_ff,
  output reg         verifyValid_ff,
  output reg         readBlocked_ff
);
  localparam ST_EXEC  = 2'b01;
  localparam ST_FLUSH = 2'b10;

  reg  [1:0]  state_ff;
  reg  [1:0]  nxt_state;
  reg         idReadPend_ff;
  reg         nxt_isByteOp;
  reg         nxt_isBitOp;
  reg         nxt_isLitCtrl;
  reg         nxt_destFile;
  reg         nxt_destAcc;
  reg         nxt_literalWide;
  reg  [10:0] nxt_literal;
  wire [1:0]  grp;
  wire        lastPhase;
  wire        idHit;
  wire        idAccess;
  wire        idWrite;
  wire        idRead;
  wire        memRead;
  wire [13:0] idRdData;

  assign grp = instrWord[`IW_GRP_HI:`IW_GRP_LO];
  assign lastPhase = (phase_ff == `PHASE_LAST);
  assign idHit = (pgmAddr >= `ID_BASE) && (pgmAddr <= `ID_LAST);
  // Normal execution never drives pgmAddr into this space outside verify mode.
  assign idAccess = progVerifyMode && idHit;
  assign idWrite = idAccess && pgmWrite;
  assign idRead = idAccess && pgmRead;
  // Reads that miss the identification words go to program memory, verify mode only.
  assign memRead = progVerifyMode && pgmRead && !idHit;

  always @(posedge clk) begin
    if (!resetn) begin
      phase_ff <= `PHASE_FIRST;
      cycleEnd_ff <= 1'b0;
    end else begin
      phase_ff <= phase_ff + 2'h1;
      // The end marker is decided one phase early so that it is a flip-flop
      // output that lines up with phase 3 rather than a decode of the count.
      cycleEnd_ff <= (phase_ff == `PHASE_LAST - 2'h1);
    end
  end

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_EXEC: begin
        if (lastPhase && pcChange) begin
          nxt_state = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        // The flushed word is a no-op and cannot branch, so pcChange is not
        // looked at here; the next word always executes.
        if (lastPhase) begin
          nxt_state = ST_EXEC;
        end
      end
      default: nxt_state = ST_EXEC;
    endcase
  end

  // Fields are decoded from the word as presented and registered only at the
  // last phase, so a word that changes again before the last phase never reaches the outputs.
  always @* begin
    nxt_isByteOp = (grp == `GRP_BYTE);
    nxt_isBitOp = (grp == `GRP_BIT);
    nxt_isLitCtrl = grp[1];
    nxt_destFile = 1'b0;
    nxt_destAcc = 1'b0;
    nxt_literalWide = 1'b0;
    nxt_literal = {3'h0, instrWord[`IW_K8_HI:0]};
    if (grp == `GRP_BYTE) begin
      nxt_destFile = instrWord[`IW_DEST_BIT];
      nxt_destAcc = !instrWord[`IW_DEST_BIT];
    end else if (grp == `GRP_CTRL) begin
      nxt_destAcc = 1'b1;
      // Control group with bit 11 clear carries the eleven-bit target.
      if (!instrWord[`IW_LIT11_BIT]) begin
        nxt_literalWide = 1'b1;
        nxt_literal = instrWord[`IW_K11_HI:0];
      end
    end else if (grp == `GRP_LIT) begin
      nxt_destAcc = 1'b1;
    end
  end

  // Decode is latched once per instruction cycle so fields stay stable for
  // all four phases; the cost is one cycle of decode latency.
  always @(posedge clk) begin
    if (!resetn) begin
      state_ff <= ST_EXEC;
      isByteOp_ff <= 1'b0;
      isBitOp_ff <= 1'b0;
      isLitCtrl_ff <= 1'b0;
      destFile_ff <= 1'b0;
      destAcc_ff <= 1'b0;
      fileAddr_ff <= 7'h00;
      bitSel_ff <= 3'h0;
      literal_ff <= 11'h000;
      literalWide_ff <= 1'b0;
      writeEn_ff <= 1'b0;
      statusEn_ff <= 1'b0;
      flushing_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (lastPhase) begin
        flushing_ff <= (nxt_state == ST_FLUSH);
        if (nxt_state == ST_FLUSH) begin
          writeEn_ff <= 1'b0;
          statusEn_ff <= 1'b0;
          isByteOp_ff <= 1'b0;
          isBitOp_ff <= 1'b0;
          isLitCtrl_ff <= 1'b0;
          destFile_ff <= 1'b0;
          destAcc_ff <= 1'b0;
        end else begin
          isByteOp_ff <= nxt_isByteOp;
          isBitOp_ff <= nxt_isBitOp;
          isLitCtrl_ff <= nxt_isLitCtrl;
          fileAddr_ff <= instrWord[`IW_FILE_HI:0];
          destFile_ff <= nxt_destFile;
          destAcc_ff <= nxt_destAcc;
          bitSel_ff <= instrWord[`IW_BIT_HI:`IW_BIT_LO];
          literalWide_ff <= nxt_literalWide;
          literal_ff <= nxt_literal;
          writeEn_ff <= 1'b1;
          statusEn_ff <= 1'b1;
        end
      end
    end
  end

  id_store u_id_store (
    .clk       (clk),
    .resetn    (resetn),
    .wrEn      (idWrite),
    .addr      (pgmAddr[1:0]),
    .wrData    (pgmWrData),
    .rdData_ff (idRdData)
  );

  always @(posedge clk) begin
    if (!resetn) begin
      idReadPend_ff <= 1'b0;
      verifyData_ff <= 14'h0000;
      verifyValid_ff <= 1'b0;
      readBlocked_ff <= 1'b0;
    end else begin
      idReadPend_ff <= idRead;
      verifyValid_ff <= 1'b0;
      readBlocked_ff <= 1'b0;
      if (memRead) begin
        if (protectProgrammed) begin
          readBlocked_ff <= 1'b1;
        end else begin
          verifyData_ff <= progMemData;
          verifyValid_ff <= 1'b1;
        end
      end
      // The identification answer is one cycle later than a memory answer, so
      // it wins if a memory read was issued right behind it.
      if (idReadPend_ff) begin
        verifyData_ff <= idRdData;
        verifyValid_ff <= 1'b1;
      end
    end
  end
endmodule // mcu_instruction_decode_idloc

// ### tb/mcu_idec_props.sv
/* Checker for the instruction decoder, bound to its top module.
   Assumes one clock and the synchronous active-low reset. */
module mcu_idec_props (
  input logic        clk,
  input logic        resetn,
  input logic [13:0] instrWord,
  input logic        pcChange,
  input logic        progVerifyMode,
  input logic        protectProgrammed,
  input logic [13:0] pgmAddr,
  input logic        pgmRead,
  input logic [13:0] progMemData,
  input logic [1:0]  phase_ff,
  input logic        cycleEnd_ff,
  input logic        destFile_ff,
  input logic [6:0]  fileAddr_ff,
  input logic [2:0]  bitSel_ff,
  input logic [10:0] literal_ff,
  input logic        literalWide_ff,
  input logic        writeEn_ff,
  input logic        statusEn_ff,
  input logic        flushing_ff,
  input logic [13:0] verifyData_ff,
  input logic        verifyValid_ff,
  input logic        readBlocked_ff
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire idAcc = pgmAddr[13:2] == 12'h800;
  wire go = cycleEnd_ff && !pcChange;
  a_phase_step: assert property ($past(resetn) |-> phase_ff == $past(phase_ff) + 2'h1)
    else $error("phase step");
  a_cycle_end: assert property (cycleEnd_ff == (phase_ff == 2'h3))
    else $error("cycle end");
  a_byte_dec: assert property (go |=> writeEn_ff && statusEn_ff
    && fileAddr_ff == $past(instrWord[6:0]) && bitSel_ff == $past(instrWord[9:7])
    && destFile_ff == ($past(instrWord[13:12]) == 2'h0 && $past(instrWord[7])))
    else $error("byte decode");
  a_lit_dec: assert property (go |=> literalWide_ff == ($past(instrWord[13:11]) == 3'h4)
    && literal_ff == (literalWide_ff ? $past(instrWord[10:0]) : {3'h0, $past(instrWord[7:0])}))
    else $error("literal decode");
  a_flush_nop: assert property (cycleEnd_ff && pcChange |=>
    (flushing_ff && !writeEn_ff && !statusEn_ff) [*4]) else $error("flush cycle");
  a_read_ok: assert property (pgmRead && progVerifyMode && !protectProgrammed && !idAcc
    |=> verifyValid_ff && verifyData_ff == $past(progMemData)) else $error("readout");
  a_read_blk: assert property (pgmRead && progVerifyMode && protectProgrammed && !idAcc
    |=> readBlocked_ff && !verifyValid_ff) else $error("blocked read");
  a_id_read: assert property (pgmRead && progVerifyMode && idAcc |-> ##2 verifyValid_ff)
    else $error("id read");
endmodule // mcu_idec_props
bind mcu_instruction_decode_idloc mcu_idec_props u_props (.*);

// ### tb/pmem_model.sv
/* Program memory model answering in the same cycle.
   Assumes the decoder reads through a combinational path. */
module pmem_model (
  input  logic [13:0] pgmAddr,
  output logic [13:0] progMemData
);
  timeunit 1ns;
  timeprecision 100ps;
  // An address pattern keeps every word distinct, so a stale answer shows.
  assign progMemData = ~pgmAddr;
endmodule // pmem_model

// ### tb/mcu_instruction_decode_idloc_bench.sv
/* Bench for the decoder: a table of words, then flush, readout and ID words.
   Assumes the program memory model on the readout side. */
module mcu_instruction_decode_idloc_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, resetn = 0, pcChange = 0, progVerifyMode = 0, protectProgrammed = 0;
  logic pgmWrite = 0, pgmRead = 0, cycleEnd_ff, isByteOp_ff, isBitOp_ff, isLitCtrl_ff;
  logic destFile_ff, destAcc_ff, literalWide_ff, writeEn_ff, statusEn_ff, flushing_ff;
  logic verifyValid_ff, readBlocked_ff;
  logic [13:0] instrWord = 0, pgmAddr = 0, pgmWrData = 0, progMemData, verifyData_ff;
  logic [1:0] phase_ff;
  logic [10:0] literal_ff;
  logic [6:0] fileAddr_ff;
  logic [2:0] bitSel_ff;
  int error_cnt = 0, checked = 0;
  // Row: word, group flags, file destination, wide literal, literal value.
  logic [29:0] rows [6] = '{{14'h0785, 5'h12, 11'h085}, {14'h0005, 5'h10, 11'h005},
    {14'h1bff, 5'h08, 11'h0ff}, {14'h27ff, 5'h05, 11'h7ff}, {14'h3a5c, 5'h04, 11'h05c},
    {14'h285c, 5'h04, 11'h05c}};
  always #12.5 clk = ~clk;
  mcu_instruction_decode_idloc u_dut (.*);
  pmem_model u_mem (.*);
  task chk(string n, logic [15:0] s, logic [15:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task close_out;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  // A word is only taken at the last phase, so wait for it under a bound.
  task dec(logic [13:0] w, logic p);
    int i;
    for (i = 0; i < 8 && phase_ff !== 2'h3; i++) tick;
    if (i == 8) begin
      error_cnt++;
      close_out;
    end
    instrWord = w;
    pcChange = p;
    tick;
    pcChange = 0;
  endtask
  task acc(logic [13:0] a, d, logic w, r, v, p);
    tick;
    pgmAddr = a;
    pgmWrData = d;
    pgmWrite = w;
    pgmRead = r;
    progVerifyMode = v;
    protectProgrammed = p;
    tick;
    pgmWrite = 0;
    pgmRead = 0;
  endtask
  initial begin
    tick;
    tick;
    chk("reset", {cycleEnd_ff, writeEn_ff, verifyValid_ff, phase_ff}, 16'h0);
    resetn = 1;
    foreach (rows[i]) begin
      dec(rows[i][29:16], 0);
      chk("group", {isByteOp_ff, isBitOp_ff, isLitCtrl_ff}, rows[i][15:13]);
      chk("dest", {destFile_ff, destAcc_ff},
        {rows[i][12], rows[i][15] & ~rows[i][12] | rows[i][13]});
      chk("file", fileAddr_ff, rows[i][22:16]);
      chk("bit", bitSel_ff, rows[i][25:23]);
      chk("literal", {literalWide_ff, literal_ff}, rows[i][11:0]);
    end
    $display("decode table done");
    dec(14'h0785, 1);
    chk("flush", {flushing_ff, writeEn_ff, statusEn_ff, isByteOp_ff}, 16'h8);
    dec(14'h0785, 0);
    chk("exec", {flushing_ff, writeEn_ff, statusEn_ff, isByteOp_ff}, 16'h7);
    $display("flush test done");
    acc(14'h0123, 14'h0, 0, 1, 1, 0);
    chk("read", {verifyValid_ff, verifyData_ff}, {1'b1, ~14'h0123});
    acc(14'h0123, 14'h0, 0, 1, 1, 1);
    chk("blocked", {readBlocked_ff, verifyValid_ff}, 16'h2);
    acc(14'h0123, 14'h0, 0, 1, 0, 0);
    chk("outside", verifyValid_ff, 16'h0);
    acc(14'h2001, 14'h000a, 1, 0, 1, 0);
    acc(14'h2001, 14'h0005, 1, 0, 0, 0);
    acc(14'h2001, 14'h0, 0, 1, 1, 0);
    tick;
    chk("id", {verifyValid_ff, verifyData_ff}, {1'b1, 14'h000a});
    $display("readout test done");
    resetn = 0;
    tick;
    tick;
    chk("reset again", {cycleEnd_ff, writeEn_ff, verifyValid_ff, readBlocked_ff, flushing_ff,
      isByteOp_ff, phase_ff}, 16'h0);
    resetn = 1;
    dec(rows[3][29:16], 0);
    chk("after reset", {literalWide_ff, literal_ff}, rows[3][11:0]);
    $display("reset test done");
    close_out;
  end
endmodule // mcu_instruction_decode_idloc_bench
